// >>> design/adcc_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// converter control front end. Included by every file that needs them.
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define ADCC_IDX_CONTROL_A 6'h00
`define ADCC_IDX_REFERENCE_CONTROL 6'h01
`define ADCC_IDX_AVERAGING_CONTROL 6'h02
`define ADCC_IDX_SAMPLING_TIME_CONTROL 6'h03
`define ADCC_IDX_CONTROL_B 6'h04
`define ADCC_IDX_STATUS 6'h19

// Control A fields
`define ADCC_CA_SOFT_RESET 0
`define ADCC_CA_ENABLE 1
`define ADCC_CA_RUN_STANDBY 2
// Reference control fields
`define ADCC_RC_COMP 7
`define ADCC_RC_SEL_LSB 0
// Averaging control fields
`define ADCC_AC_DIV_LSB 4
`define ADCC_AC_CNT_LSB 0
// Control B fields
`define ADCC_CB_DIFF 0
`define ADCC_CB_LEFT 1
`define ADCC_CB_FREE 2
`define ADCC_CB_CORR 3
`define ADCC_CB_RES_LSB 4
`define ADCC_CB_PRESC_LSB 8
// Status fields
`define ADCC_ST_BUSY 7

// Writable bits; all others are reserved and read zero
`define ADCC_MASK_CONTROL_A 16'h0007
`define ADCC_MASK_REFERENCE 16'h008F
`define ADCC_MASK_AVERAGING 16'h007F
`define ADCC_MASK_SAMPLING 16'h003F
`define ADCC_MASK_CONTROL_B 16'h073F

// Reset values
`define ADCC_RST_8 8'h00
`define ADCC_RST_16 16'h0000

// Highest legal codes
`define ADCC_REF_SEL_MAX 4'h4
`define ADCC_SAMPLE_CNT_MAX 4'hA

// Converter clock ticks a synchronised access needs to take effect
`define ADCC_SYNC_TICKS 2'd2
// Smallest prescaler divide ratio
`define ADCC_PRESC_BASE 10'h004

// Bus responses
`define ADCC_RESP_OKAY 2'b00
`define ADCC_RESP_SLVERR 2'b10
`define ADCC_RESP_DECERR 2'b11

`endif

// >>> design/adcc_clk_div.sv
// Converter clock divider: one-cycle tick every 4 << prescale core cycles.
// Assumes prescale is stable except when restart is pulsed.
`timescale 1ns/10ps
`include "adcc_cfg.svh"
module adcc_clk_div #(
  parameter int PRESC_W = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire logic [PRESC_W-1:0] prescale,
  // Converter clock enable
  output logic tick
);

  initial begin
    if (PRESC_W != 3) begin
      $error("adcc_clk_div: only a 3-bit prescaler is served");
    end
  end

  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
  } adcc_div_s;

  adcc_div_s div_reg;
  adcc_div_s div_next;
  logic [9:0] ratio;

  always_comb begin
    div_next = div_reg;
    ratio = `ADCC_PRESC_BASE << prescale;
    div_next.tick = 1'b0;
    if (restart) begin
      div_next.cnt = 9'h000;
    end else if ({1'b0, div_reg.cnt} == ratio - 10'h001) begin
      div_next.cnt = 9'h000;
      div_next.tick = 1'b1;
    end else begin
      div_next.cnt = div_reg.cnt + 9'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick = div_reg.tick;

endmodule

// >>> design/adcc_pkg.sv
// Types shared by the converter control front end.
// Assumes the constants of adcc_cfg.svh for field positions.
package adcc_pkg;

  typedef enum logic [3:0] {
    internal_one_volt_ref = 4'h0,
    supply_div_1p48_ref = 4'h1,
    supply_div_2_ref = 4'h2,
    external_ref_a = 4'h3,
    external_ref_b = 4'h4
  } adcc_ref_e;

  typedef enum logic [1:0] {
    res_12_bit = 2'h0,
    res_16_bit = 2'h1,
    res_10_bit = 2'h2,
    res_8_bit = 2'h3
  } adcc_res_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } adcc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcc_axi_rsp_s;

  typedef struct packed {
    logic converter_enabled;
    logic keep_running_in_standby;
    logic ref_buffer_offset_comp;
    logic [3:0] reference_select;
    logic reference_reserved;
    logic [2:0] result_division_exponent;
    logic [10:0] samples_per_result;
    logic sample_count_reserved;
    logic [6:0] sampling_half_cycles;
    logic [1:0] resolution_select;
    logic [4:0] result_width;
    logic digital_correction_on;
    logic continuous_conversion;
    logic left_align_result;
    logic differential_input;
    logic [2:0] prescaler_select;
  } adcc_cfg_s;

endpackage

// >>> design/adcc_regs.sv
// Converter control register front end on an AXI4-Lite slave port.
// Assumes one core clock; the converter domain runs on divider ticks.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "adcc_cfg.svh"
module adcc_regs #(
  parameter int ADDR_W = 8,
  parameter int PRESC_W = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire adcc_pkg::adcc_axi_req_s axi_req,
  output adcc_pkg::adcc_axi_rsp_s axi_rsp,
  // Write protection from the peripheral access guard
  input wire logic peripheral_access_guard,
  // Configuration towards the converter
  output adcc_pkg::adcc_cfg_s conv_cfg,
  output logic conv_clk_tick
);

  initial begin
    if (ADDR_W < 7 || ADDR_W > 8) begin
      $error("adcc_regs: address width must be 7 or 8 bits");
    end
    if (PRESC_W != 3) begin
      $error("adcc_regs: only a 3-bit prescaler is served");
    end
  end

  typedef struct packed {
    logic [7:0] control_a;
    logic [7:0] reference_control;
    logic [7:0] averaging_control;
    logic [7:0] sampling_time_control;
    logic [15:0] control_b;
    logic [15:0] control_b_conv;
    logic conv_enable;
    logic sync_busy_flag;
    logic [1:0] sync_cnt;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    adcc_pkg::adcc_axi_rsp_s rsp;
    adcc_pkg::adcc_cfg_s cfg;
    logic tick;
  } adcc_state_s;

  adcc_state_s st_reg;
  adcc_state_s st_next;
  logic div_tick;
  logic div_restart;

  // Byte-lane merge with reserved bits forced to zero
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] strb,
    input logic [15:0] mask
  );
    logic [15:0] res;
    res = old;
    for (int i = 0; i < 2; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res & mask;
  endfunction

  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  function automatic logic [4:0] width_of(input logic [1:0] sel);
    logic [4:0] w;
    case (sel)
      adcc_pkg::res_12_bit: w = 5'd12;
      adcc_pkg::res_16_bit: w = 5'd16;
      adcc_pkg::res_10_bit: w = 5'd10;
      default: w = 5'd8;
    endcase
    return w;
  endfunction

  always_comb begin
    logic [5:0] widx;
    logic [5:0] ridx;
    logic [15:0] merged;
    logic [15:0] wlo;
    logic [3:0] cnt_code;
    logic [3:0] ref_code;
    logic [7:0] waddr;
    logic [7:0] raddr;
    widx = 6'h00;
    ridx = 6'h00;
    merged = 16'h0000;
    wlo = 16'h0000;
    cnt_code = 4'h0;
    ref_code = 4'h0;
    waddr = 8'h00;
    raddr = 8'h00;
    st_next = st_reg;
    st_next.tick = div_tick;

    // Converter-domain side of the synchronisation handshake
    if (st_reg.sync_busy_flag && div_tick) begin
      if (st_reg.sync_cnt == `ADCC_SYNC_TICKS - 2'd1) begin
        st_next.sync_busy_flag = 1'b0;
        st_next.sync_cnt = 2'd0;
        if (st_reg.control_a[`ADCC_CA_SOFT_RESET]) begin
          // Debug control lives elsewhere and is untouched
          st_next.control_a = `ADCC_RST_8;
          st_next.reference_control = `ADCC_RST_8;
          st_next.averaging_control = `ADCC_RST_8;
          st_next.sampling_time_control = `ADCC_RST_8;
          st_next.control_b = `ADCC_RST_16;
          st_next.control_b_conv = `ADCC_RST_16;
          st_next.conv_enable = 1'b0;
        end else begin
          st_next.conv_enable = st_reg.control_a[`ADCC_CA_ENABLE];
          st_next.control_b_conv = st_reg.control_b;
        end
      end else begin
        st_next.sync_cnt = st_reg.sync_cnt + 2'd1;
      end
    end

    // Write address and data are taken independently
    if (axi_req.awvalid && st_reg.rsp.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_reg.rsp.wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = axi_req.wdata;
      st_next.w_strb = axi_req.wstrb;
    end
    if (st_reg.rsp.bvalid && axi_req.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end

    if (st_reg.aw_full && st_reg.w_full && !st_reg.rsp.bvalid) begin
      waddr = st_reg.aw_addr;
      widx = reg_index(waddr);
      wlo = st_reg.w_data[15:0];
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = `ADCC_RESP_OKAY;
      case (widx)
        `ADCC_IDX_CONTROL_A, `ADCC_IDX_REFERENCE_CONTROL,
        `ADCC_IDX_AVERAGING_CONTROL, `ADCC_IDX_SAMPLING_TIME_CONTROL,
        `ADCC_IDX_CONTROL_B: begin
          if (peripheral_access_guard) begin
            st_next.rsp.bresp = `ADCC_RESP_SLVERR;
          end else if (st_reg.control_a[`ADCC_CA_SOFT_RESET]) begin
            // Nothing may land while the reset is still in flight
            st_next.rsp.bresp = `ADCC_RESP_SLVERR;
          end else begin
            case (widx)
              `ADCC_IDX_CONTROL_A: begin
                if (st_reg.w_strb[0] && wlo[`ADCC_CA_SOFT_RESET]) begin
                  // Only the reset request survives this access
                  st_next.control_a = st_reg.control_a;
                  st_next.control_a[`ADCC_CA_SOFT_RESET] = 1'b1;
                  st_next.sync_busy_flag = 1'b1;
                  st_next.sync_cnt = 2'd0;
                end else begin
                  merged = lane_merge({8'h00, st_reg.control_a}, wlo,
                    st_reg.w_strb[1:0], `ADCC_MASK_CONTROL_A);
                  st_next.control_a = merged[7:0];
                  if (merged[`ADCC_CA_ENABLE] !=
                      st_reg.control_a[`ADCC_CA_ENABLE]) begin
                    st_next.sync_busy_flag = 1'b1;
                    st_next.sync_cnt = 2'd0;
                  end
                end
              end
              `ADCC_IDX_REFERENCE_CONTROL: begin
                merged = lane_merge({8'h00, st_reg.reference_control},
                  wlo, st_reg.w_strb[1:0], `ADCC_MASK_REFERENCE);
                st_next.reference_control = merged[7:0];
              end
              `ADCC_IDX_AVERAGING_CONTROL: begin
                merged = lane_merge({8'h00, st_reg.averaging_control},
                  wlo, st_reg.w_strb[1:0], `ADCC_MASK_AVERAGING);
                st_next.averaging_control = merged[7:0];
              end
              `ADCC_IDX_SAMPLING_TIME_CONTROL: begin
                merged = lane_merge({8'h00, st_reg.sampling_time_control},
                  wlo, st_reg.w_strb[1:0], `ADCC_MASK_SAMPLING);
                st_next.sampling_time_control = merged[7:0];
              end
              default: begin
                // Control B holds its value while the enable bit of Control A is set
                if (!st_reg.control_a[`ADCC_CA_ENABLE]) begin
                  st_next.control_b = lane_merge(st_reg.control_b, wlo,
                    st_reg.w_strb[1:0], `ADCC_MASK_CONTROL_B);
                  st_next.sync_busy_flag = 1'b1;
                  st_next.sync_cnt = 2'd0;
                end else begin
                  st_next.control_b = st_reg.control_b;
                end
              end
            endcase
          end
        end
        `ADCC_IDX_STATUS: begin
          st_next.rsp.bresp = `ADCC_RESP_OKAY;
        end
        default: begin
          st_next.rsp.bresp = `ADCC_RESP_DECERR;
        end
      endcase
    end

    // Read channel: answer one cycle after the address is taken
    if (st_reg.rsp.rvalid && axi_req.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_reg.rsp.arready) begin
      raddr = axi_req.araddr;
      ridx = reg_index(raddr);
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rresp = `ADCC_RESP_OKAY;
      st_next.rsp.rdata = 32'h0000_0000;
      case (ridx)
        `ADCC_IDX_CONTROL_A:
          st_next.rsp.rdata[7:0] = st_reg.control_a;
        `ADCC_IDX_REFERENCE_CONTROL:
          st_next.rsp.rdata[7:0] = st_reg.reference_control;
        `ADCC_IDX_AVERAGING_CONTROL:
          st_next.rsp.rdata[7:0] = st_reg.averaging_control;
        `ADCC_IDX_SAMPLING_TIME_CONTROL:
          st_next.rsp.rdata[7:0] = st_reg.sampling_time_control;
        `ADCC_IDX_CONTROL_B:
          st_next.rsp.rdata[15:0] = st_reg.control_b;
        `ADCC_IDX_STATUS:
          st_next.rsp.rdata[`ADCC_ST_BUSY] = st_reg.sync_busy_flag;
        default:
          st_next.rsp.rresp = `ADCC_RESP_DECERR;
      endcase
    end

    // One write and one read in flight; ready drops while held
    st_next.rsp.awready = !st_next.aw_full && !st_next.rsp.bvalid;
    st_next.rsp.wready = !st_next.w_full && !st_next.rsp.bvalid;
    st_next.rsp.arready = !st_next.rsp.rvalid;

    // Configuration seen by the converter, registered
    st_next.cfg.converter_enabled = st_reg.conv_enable;
    st_next.cfg.keep_running_in_standby =
      st_reg.control_a[`ADCC_CA_RUN_STANDBY];
    st_next.cfg.ref_buffer_offset_comp =
      st_reg.reference_control[`ADCC_RC_COMP];
    ref_code = st_reg.reference_control[`ADCC_RC_SEL_LSB +: 4];
    st_next.cfg.reference_select = ref_code;
    st_next.cfg.reference_reserved = ref_code > `ADCC_REF_SEL_MAX;
    st_next.cfg.result_division_exponent =
      st_reg.averaging_control[`ADCC_AC_DIV_LSB +: 3];
    cnt_code = st_reg.averaging_control[`ADCC_AC_CNT_LSB +: 4];
    // Reserved counts give zero so the datapath can refuse them
    if (cnt_code > `ADCC_SAMPLE_CNT_MAX) begin
      st_next.cfg.samples_per_result = 11'h000;
      st_next.cfg.sample_count_reserved = 1'b1;
    end else begin
      st_next.cfg.samples_per_result = 11'h001 << cnt_code;
      st_next.cfg.sample_count_reserved = 1'b0;
    end
    st_next.cfg.sampling_half_cycles =
      {1'b0, st_reg.sampling_time_control[5:0]} + 7'h01;
    st_next.cfg.resolution_select =
      st_reg.control_b_conv[`ADCC_CB_RES_LSB +: 2];
    st_next.cfg.result_width =
      width_of(st_reg.control_b_conv[`ADCC_CB_RES_LSB +: 2]);
    st_next.cfg.digital_correction_on =
      st_reg.control_b_conv[`ADCC_CB_CORR];
    st_next.cfg.continuous_conversion =
      st_reg.control_b_conv[`ADCC_CB_FREE];
    st_next.cfg.left_align_result = st_reg.control_b_conv[`ADCC_CB_LEFT];
    st_next.cfg.differential_input = st_reg.control_b_conv[`ADCC_CB_DIFF];
    st_next.cfg.prescaler_select =
      st_reg.control_b_conv[`ADCC_CB_PRESC_LSB +: 3];
  end

  // Restart the divider whenever a new prescaler reaches the converter
  assign div_restart = st_reg.control_b_conv[`ADCC_CB_PRESC_LSB +: 3] !=
    st_next.control_b_conv[`ADCC_CB_PRESC_LSB +: 3];

  adcc_clk_div #(
    .PRESC_W(PRESC_W)
  ) u_clk_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .restart(div_restart),
    .prescale(st_reg.control_b_conv[`ADCC_CB_PRESC_LSB +: 3]),
    .tick(div_tick)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.rsp.awready <= 1'b1;
      st_reg.rsp.wready <= 1'b1;
      st_reg.rsp.arready <= 1'b1;
      st_reg.cfg.samples_per_result <= 11'h001;
      st_reg.cfg.sampling_half_cycles <= 7'h01;
      st_reg.cfg.result_width <= 5'd12;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axi_rsp = st_reg.rsp;
  assign conv_cfg = st_reg.cfg;
  assign conv_clk_tick = st_reg.tick;

endmodule

// >>> dv/adcc_regs_assertions.sv
// Concurrent checks on the ports of the converter control front end.
// Assumes one core clock domain and the constants of adcc_cfg.svh.
`timescale 1ns/10ps
`include "adcc_cfg.svh"
module adcc_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus and guard
  input wire adcc_pkg::adcc_axi_req_s axi_req,
  input wire adcc_pkg::adcc_axi_rsp_s axi_rsp,
  input wire logic peripheral_access_guard,
  // Converter side
  input wire adcc_pkg::adcc_cfg_s conv_cfg,
  input wire logic conv_clk_tick
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_b_hold;
    axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");

  property p_r_answer;
    axi_req.arvalid && axi_rsp.arready |=> ##[0:1] axi_rsp.rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");

  property p_r_hold;
    axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");

  property p_upper_zero;
    axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unused read bits not zero");

  property p_guard;
    axi_req.awvalid && axi_rsp.awready && peripheral_access_guard &&
      axi_req.awaddr < 8'h14 |-> ##[1:3]
      (axi_rsp.bvalid && axi_rsp.bresp == `ADCC_RESP_SLVERR);
  endproperty
  a_guard: assert property (p_guard)
    else $error("guarded write not refused");

  property p_ref_flag;
    conv_cfg.reference_reserved == (conv_cfg.reference_select > 4'h4);
  endproperty
  a_ref_flag: assert property (p_ref_flag)
    else $error("reference reserved flag wrong");

  property p_samples;
    conv_cfg.sample_count_reserved ? conv_cfg.samples_per_result == 11'h000
      : $onehot(conv_cfg.samples_per_result);
  endproperty
  a_samples: assert property (p_samples)
    else $error("sample count not a power of two");

  property p_width;
    conv_cfg.result_width == (conv_cfg.resolution_select == 2'h0 ? 5'h0C :
      conv_cfg.resolution_select == 2'h1 ? 5'h10 :
      conv_cfg.resolution_select == 2'h2 ? 5'h0A : 5'h08);
  endproperty
  a_width: assert property (p_width)
    else $error("result width does not match resolution");

  // Fastest divide only; the tick that brings a new prescaler restarts
  // the divider, so it must still see the fast setting a cycle later
  property p_tick;
    conv_clk_tick && conv_cfg.prescaler_select == 3'h0 ##1
      conv_cfg.prescaler_select == 3'h0 |->
      !conv_clk_tick [*3] ##1 conv_clk_tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("converter tick spacing wrong");

  property p_en_tick;
    $changed(conv_cfg.converter_enabled) |-> $past(conv_clk_tick) ||
      $past(conv_clk_tick, 2) || $past(conv_clk_tick, 3);
  endproperty
  a_en_tick: assert property (p_en_tick)
    else $error("enable changed off the converter clock");

  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_refused: cover property (axi_rsp.bvalid &&
    axi_rsp.bresp == `ADCC_RESP_SLVERR);
  c_read: cover property (axi_rsp.rvalid && axi_req.rready);
  c_enable: cover property ($rose(conv_cfg.converter_enabled));
endmodule

bind adcc_regs adcc_chk u_chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .peripheral_access_guard(peripheral_access_guard),
  .conv_cfg(conv_cfg),
  .conv_clk_tick(conv_clk_tick)
);

// >>> dv/tb.sv
// Self-checking bench for the converter control front end.
// Drives adcc_regs directly over AXI4-Lite; the checker is bound.
`timescale 1ns/10ps
`include "adcc_cfg.svh"
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic guard = 1'b0;
  adcc_pkg::adcc_axi_req_s req = '0;
  adcc_pkg::adcc_axi_rsp_s rsp;
  adcc_pkg::adcc_cfg_s cfg;
  logic tick;
  int num_errors = 0;
  int num_checks = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  localparam logic [7:0] addr_ca = {`ADCC_IDX_CONTROL_A, 2'b00};
  localparam logic [7:0] addr_rc = {`ADCC_IDX_REFERENCE_CONTROL, 2'b00};
  localparam logic [7:0] addr_ac = {`ADCC_IDX_AVERAGING_CONTROL, 2'b00};
  localparam logic [7:0] addr_sc = {`ADCC_IDX_SAMPLING_TIME_CONTROL, 2'b00};
  localparam logic [7:0] addr_cb = {`ADCC_IDX_CONTROL_B, 2'b00};
  localparam logic [7:0] addr_st = {`ADCC_IDX_STATUS, 2'b00};

  always #4 core_clk = ~core_clk;

  adcc_regs dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .axi_req(req),
    .axi_rsp(rsp),
    .peripheral_access_guard(guard),
    .conv_cfg(cfg),
    .conv_clk_tick(tick)
  );

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen,
               exp);
    end
  endtask

  task automatic step(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 2000) begin
      num_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask

  // The read ready line rises a cycle after rvalid, so the read answer has to stand; bready rises in the same cycle as bvalid
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    int n;
    bit aw;
    bit w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= s;
    while (aw || w) begin
      step(n);
      if (aw && rsp.awready === 1'b1) begin
        req.awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        req.wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    step(n);
    req.bready <= 1'b1;
    do step(n); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do step(n); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    step(n);
    req.rready <= 1'b1;
    do step(n); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic wait_sync;
    for (int k = 0; k < 300; k++) begin
      rd_reg(addr_st);
      if (rd[`ADCC_ST_BUSY] === 1'b0) return;
    end
    num_errors++;
    $display("wrong value at %0t: busy never cleared", $time);
    tally_and_finish();
  endtask

  task automatic test_reset;
    for (int i = 0; i < 5; i++) begin
      rd_reg(8'(i * 4));
      check(rd, 32'h0000_0000, "reset value");
    end
    check(32'(cfg.samples_per_result), 32'h0000_0001, "samples");
    check(32'(cfg.sampling_half_cycles), 32'h0000_0001, "len");
    check(32'(cfg.result_width), 32'h0000_000C, "width");
    $display("test_reset done");
  endtask

  task automatic test_fields;
    logic [15:0] exp [5] = '{16'h0006, 16'h008F, 16'h007F, 16'h003F,
                             16'h013F};
    for (int i = 1; i < 6; i++) begin
      wr(8'((i % 5) * 4), (i == 4) ? 16'hF9FF : (i == 5) ? 16'h00FE
         : 16'hFFFF, 4'hF);
      check(32'(resp), 32'(`ADCC_RESP_OKAY), "bresp");
      rd_reg(8'((i % 5) * 4));
      check(rd, 32'(exp[i % 5]), "reserved bits");
    end
    wait_sync();
    check(32'({cfg.keep_running_in_standby, cfg.converter_enabled}),
          32'h0000_0003, "standby enable");
    check(32'({cfg.ref_buffer_offset_comp, cfg.reference_reserved,
          cfg.result_division_exponent, cfg.sample_count_reserved}),
          32'h0000_003F, "ref avg");
    check(32'(cfg.sampling_half_cycles), 32'h0000_0040, "len");
    check(32'({cfg.prescaler_select, cfg.result_width,
          cfg.digital_correction_on, cfg.continuous_conversion,
          cfg.left_align_result, cfg.differential_input}),
          32'h0000_028F, "control b");
    $display("test_fields done");
  endtask

  task automatic test_protect;
    wr(addr_cb, 16'h0000, 4'hF);
    check(32'(resp), 32'(`ADCC_RESP_OKAY), "enabled write");
    rd_reg(addr_cb);
    check(rd, 32'h0000_013F, "kept while enabled");
    guard <= 1'b1;
    wr(addr_rc, 16'h0000, 4'hF);
    check(32'(resp), 32'(`ADCC_RESP_SLVERR), "guarded");
    guard <= 1'b0;
    rd_reg(addr_rc);
    check(rd, 32'h0000_008F, "guarded kept");
    wr(8'h14, 16'h00FF, 4'hF);
    check(32'(resp), 32'(`ADCC_RESP_DECERR), "unmapped write");
    rd_reg(8'h20);
    check({rd[29:0], resp}, {30'h0, `ADCC_RESP_DECERR}, "unmapped");
    $display("test_protect done");
  endtask

  task automatic test_soft_reset;
    wr(addr_ca, 16'h0001, 4'h1);
    rd_reg(addr_ca);
    check(rd, 32'h0000_0007, "reset pending");
    rd_reg(addr_st);
    check(32'(rd[`ADCC_ST_BUSY]), 32'h0000_0001, "busy");
    wait_sync();
    for (int i = 0; i < 5; i++) begin
      rd_reg(8'(i * 4));
      check(rd, 32'h0000_0000, "after reset");
    end
    check(32'(cfg.converter_enabled), 32'h0000_0000, "disabled");
    wr(addr_ac, 16'h0004, 4'h1);
    // Sixteen summed samples need the wide result
    wr(addr_cb, 16'h0010, 4'h3);
    wait_sync();
    check(32'(cfg.result_width), 32'h0000_0010, "width 16");
    check(32'(cfg.samples_per_result), 32'h0000_0010, "avg 16");
    $display("test_soft_reset done");
  endtask

  task automatic test_enable_sync;
    wr(addr_cb, 16'h0721, 4'h1);
    rd_reg(addr_cb);
    check(rd, 32'h0000_0021, "low lane");
    wr(addr_cb, 16'h0300, 4'h2);
    rd_reg(addr_cb);
    check(rd, 32'h0000_0321, "high lane");
    wait_sync();
    check(32'(cfg.result_width), 32'h0000_000A, "width 10");
    wr(addr_ca, 16'h0002, 4'h1);
    rd_reg(addr_ca);
    check(rd, 32'h0000_0002, "enable readback");
    rd_reg(addr_st);
    check(32'(rd[`ADCC_ST_BUSY]), 32'h0000_0001, "busy set");
    check(32'(cfg.converter_enabled), 32'h0000_0000, "not yet");
    wait_sync();
    check(32'(cfg.converter_enabled), 32'h0000_0001, "enabled");
    $display("test_enable_sync done");
  endtask

  task automatic test_codes;
    for (int n = 0; n < 12; n++) begin
      wr(addr_rc, 16'(n), 4'h1);
      wr(addr_ac, 16'(n | ((n % 8) << 4)), 4'h1);
      wr(addr_sc, 16'(n * 5), 4'h1);
      repeat (2) @(posedge core_clk);
      check(32'({cfg.reference_reserved, cfg.reference_select,
            cfg.result_division_exponent}), 32'({n > 4, 4'(n),
            3'(n % 8)}), "ref div");
      check(32'(cfg.samples_per_result), (n <= 10) ? 32'(1 << n)
            : 32'h0000_0000, "samples");
      check(32'(cfg.sampling_half_cycles), 32'(n * 5 + 1), "len");
    end
    $display("test_codes done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    test_reset();
    test_fields();
    test_protect();
    test_soft_reset();
    test_enable_sync();
    test_codes();
    tally_and_finish();
  end
endmodule
